/* File: bench/lei_ctrl_model.sv */
// bench model of the controller that clocks the serial position link
`default_nettype none
module lei_ctrl_model #(
	parameter int HALF_NS = 250
) (
	output var logic ser_clk,
	input wire logic ser_data
);
	timeunit 1ns;
	timeprecision 1ps;
	initial ser_clk = 1'b1;
	// link clock idles high and only toggles inside a frame
	task automatic read_frame(input int nbits, output logic [31:0] word);
		word = '0;
		for (int i = 0; i < nbits; i++) begin
			ser_clk = 1'b0;
			#HALF_NS;
			word = {word[30:0], ser_data};
			ser_clk = 1'b1;
			#HALF_NS;
		end
	endtask
endmodule
`default_nettype wire

/* File: bench/linear_encoder_output_interfaces_tb.sv */
// testbench for the encoder output block
`default_nettype none
module linear_encoder_output_interfaces_tb
	import lei_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst, ref_in, err_in, warn_in, hyb, prx, we;
	logic qa, qb, rip, sdat, ptx, poe, bsy;
	logic [31:0] pos, got, exp_w;
	logic [2:0] res_sel;
	logic [3:0] cfg_sel, waddr;
	logic [7:0] wdata, rdata, id_val;
	logic [1:0] qprev;
	wire logic ser_clk;
	int n_errors = 0;
	int n_compared = 0;
	int lfsr_st = 65;
	int net_units = 0;
	int stepu = 8;
	int nb, k;
	lei_encoder_out dut_u (
		.clk(clk), .rst(rst), .position_units(pos), .ref_mark_seen(ref_in),
		.pos_error(err_in), .pos_warning(warn_in),
		.fine_interpolation_option(res_sel[0]), .medium_interpolation_option(res_sel[1]),
		.coarse_interpolation_option(res_sel[2]),
		.serial_cfg_22bit(cfg_sel[0]), .serial_cfg_25bit(cfg_sel[1]),
		.serial_cfg_27bit(cfg_sel[2]), .serial_cfg_gray_28bit(cfg_sel[3]),
		.hybrid_interface_option(hyb), .ser_clk(ser_clk), .param_rx(prx),
		.store_wdata(wdata), .store_addr(waddr), .store_we(we),
		.quad_a(qa), .quad_b(qb), .reference_index_pulse(rip), .ser_data(sdat),
		.param_tx(ptx), .param_tx_oe(poe), .store_rdata(rdata), .frame_busy(bsy)
	);
	lei_ctrl_model ctrl_u (.ser_clk(ser_clk), .ser_data(sdat));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	task finish_test();
		$display("errors %0d compared %0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task check(input logic [31:0] g, input logic [31:0] e, input string msg);
		n_compared++;
		if (g !== e) begin
			n_errors++;
			$display("unexpected at %0t: %s got %h exp %h", $time, msg, g, e);
		end
	endtask
	task tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	function automatic int lfsr();
		lfsr_st = ((lfsr_st << 1) | (((lfsr_st >> 15) ^ (lfsr_st >> 13) ^ (lfsr_st >> 12)
			^ (lfsr_st >> 10)) & 1)) & 32'hFFFF;
		return lfsr_st;
	endfunction
	function automatic int qidx(logic [1:0] ab);
		return (ab == 2'h0) ? 0 : (ab == 2'h2) ? 1 : (ab == 2'h3) ? 2 : 3;
	endfunction
	// integer model of the receiving counter: every edge of both outputs counts
	always @(posedge clk) begin
		if (!rst && {qa, qb} !== qprev) begin
			case ((qidx({qa, qb}) - qidx(qprev)) & 3)
				1: net_units += stepu;
				3: net_units -= stepu;
				default: check(32'h1, 32'h0, "quad double step");
			endcase
		end
		qprev <= {qa, qb};
	end
	function automatic logic [31:0] frame_exp(int c, logic [31:0] p, logic e, logic w,
		output int n);
		logic [31:0] f;
		n = 28;
		case (c)
			0: begin
				f = (p / 80) & 32'h3FFFFF;
				n = 25;
				return (f << 3) | {29'h0, ^f, e, w};
			end
			1: begin
				f = (p / 8) & 32'h1FFFFFF;
				return (f << 3) | {29'h0, ^f, e, w};
			end
			2: begin
				f = (p / 2) & 32'h7FFFFFF;
				return (f << 1) | {31'h0, e};
			end
			default: begin
				f = p & 32'hFFFFFFF;
				return f ^ (f >> 1);
			end
		endcase
	endfunction
	task store_wr(input logic [3:0] a, input logic [7:0] d);
		waddr = a;
		wdata = d;
		we = 1'b1;
		tick(1);
		we = 1'b0;
		tick(2);
	endtask
	task settle();
		for (int i = 0; i < 20000 && net_units != pos; i++)
			tick(1);
		tick(8);
		check(32'(net_units), pos, "quad position");
	endtask
	initial begin
		#600us;
		n_errors++;
		$display("unexpected at %0t: watchdog", $time);
		finish_test();
	end
	initial begin
		rst = 1'b1;
		pos = '0;
		{ref_in, err_in, warn_in, we} = 4'h0;
		{hyb, prx} = 2'h3;
		res_sel = 3'h1;
		cfg_sel = 4'h1;
		waddr = 4'h0;
		wdata = 8'h00;
		tick(4);
		rst = 1'b0;
		for (int i = 0; i < 4; i++) begin
			k = lfsr();
			ref_in = k[0];
			prx = k[1];
			tick(1);
			check(rip, ref_in, "reference copy");
			tick(3);
			check({ptx, poe}, {prx, ~prx}, "parameter echo");
		end
		id_val = 8'(lfsr());
		store_wr(4'h3, id_val);
		check(rdata, id_val, "store write");
		hyb = 1'b0;
		store_wr(4'h3, ~id_val);
		check({rdata, poe}, {id_val, 1'b0}, "store locked");
		hyb = 1'b1;
		waddr = 4'h0;
		tick(2);
		check(rdata, LEI_ID_BYTE, "identity value");
		id_val = LEI_ID_BYTE;
		store_wr(4'h0, ~id_val);
		check(rdata, id_val, "identity read only");
		for (int o = 0; o < 3; o++) begin
			res_sel = 3'(1 << o);
			stepu = LEI_UNITS_PER_UM * ((o == 0) ? LEI_STEP_FINE_UM : (o == 1) ?
				LEI_STEP_MEDIUM_UM : LEI_STEP_COARSE_UM);
			k = lfsr() % 8 + 1;
			pos = pos + 32'(k * 80);
			settle();
			pos = pos - 32'(k * 80);
			settle();
		end
		res_sel = 3'h4;
		stepu = 80;
		for (int c = 0; c < 4; c++) begin
			k = lfsr();
			cfg_sel = 4'(1 << c);
			pos = 32'((k % 4096) * 80);
			err_in = k[12];
			warn_in = k[13];
			exp_w = frame_exp(c, pos, err_in, warn_in, nb);
			tick(2);
			ctrl_u.read_frame(nb, got);
			check(got, exp_w, "frame word");
			check(bsy, 1'b1, "busy in frame");
			for (int i = 0; i < LEI_MONO_CYC + 100 && bsy !== 1'b0; i++)
				tick(1);
			check({bsy, sdat}, 2'h1, "link idle");
			settle();
		end
		finish_test();
	end
endmodule
`default_nettype wire

/* File: rtl/lei_buf_if.sv */
// interface: valid/ready word path between producer and two-entry buffer
`default_nettype none
interface lei_buf_if;
	logic valid;
	logic ready;
	logic [31:0] data;
	modport src(output valid, output data, input ready);
	modport dst(input valid, input data, output ready);
endinterface
`default_nettype wire

/* File: rtl/lei_encoder_out.sv */
// top: quadrature, reference and serial absolute outputs of the scanner
// Behaviour
// - the two incremental outputs are square waves a quarter period apart.
// - one transition on the pair stands for 1, 5 or 10 um as the interpolation option selects.
// - the serial variant shifts the absolute position out as a data word.
// - quadrature outputs keep running while a serial transfer is in progress.
// - the position field is 22, 25 or 27 bits binary, or 28 bits Gray.
// - 22 and 25 bit frames add even parity, error and warning, 27 bit only error, Gray none.
// - one serial count is 10, 1, 0.25 or 0.125 um in order of rising width.
// - the hybrid variant has a two-way parameter channel with 1.25 um position resolution; here the channel only echoes param_rx and carries no position.
// - the hybrid variant holds readable identity data and a writable drive store.
// - in the positive direction the second output lags the first, else it leads.
`default_nettype none
module lei_encoder_out
	import lei_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [LEI_POS_W-1:0] position_units,
	input wire logic ref_mark_seen,
	input wire logic pos_error,
	input wire logic pos_warning,
	input wire logic fine_interpolation_option,
	input wire logic medium_interpolation_option,
	input wire logic coarse_interpolation_option,
	input wire logic serial_cfg_22bit,
	input wire logic serial_cfg_25bit,
	input wire logic serial_cfg_27bit,
	input wire logic serial_cfg_gray_28bit,
	input wire logic hybrid_interface_option,
	input wire logic ser_clk,
	input wire logic param_rx,
	input wire logic [7:0] store_wdata,
	input wire logic [3:0] store_addr,
	input wire logic store_we,
	output logic quad_a,
	output logic quad_b,
	output logic reference_index_pulse,
	output logic ser_data,
	output logic param_tx,
	output logic param_tx_oe,
	output logic [7:0] store_rdata,
	output logic frame_busy
);
	lei_res_t res_sel;
	lei_ser_t ser_sel;
	always_comb begin
		if (coarse_interpolation_option) begin
			res_sel = LEI_RES_COARSE;
		end else if (medium_interpolation_option) begin
			res_sel = LEI_RES_MEDIUM;
		end else begin
			res_sel = LEI_RES_FINE;
		end
		if (serial_cfg_gray_28bit) begin
			ser_sel = LEI_SER_G28;
		end else if (serial_cfg_27bit) begin
			ser_sel = LEI_SER_27;
		end else if (serial_cfg_25bit) begin
			ser_sel = LEI_SER_25;
		end else begin
			ser_sel = LEI_SER_22;
		end
	end
	// quadrature stepper: position units are 0.125 um
	logic [LEI_POS_W-1:0] step_units;
	always_comb begin
		unique case (res_sel)
			LEI_RES_FINE: step_units = LEI_POS_W'(LEI_STEP_FINE_UM * LEI_UNITS_PER_UM);
			LEI_RES_MEDIUM: step_units = LEI_POS_W'(LEI_STEP_MEDIUM_UM * LEI_UNITS_PER_UM);
			LEI_RES_COARSE: step_units = LEI_POS_W'(LEI_STEP_COARSE_UM * LEI_UNITS_PER_UM);
			default: step_units = LEI_POS_W'(LEI_STEP_FINE_UM * LEI_UNITS_PER_UM);
		endcase
	end
	logic [LEI_POS_W-1:0] out_pos_ff;
	logic [1:0] phase_ff;
	logic [LEI_POS_W-1:0] diff;
	logic fwd;
	logic back;
	assign diff = position_units - out_pos_ff;
	assign fwd = !diff[LEI_POS_W-1] && (diff >= step_units);
	assign back = diff[LEI_POS_W-1] && ((LEI_POS_W'(0) - diff) >= step_units);
	always_ff @(posedge clk) begin
		if (rst) begin
			out_pos_ff <= '0;
			phase_ff <= LEI_QUAD_RST;
		end else if (fwd) begin
			out_pos_ff <= out_pos_ff + step_units;
			phase_ff <= phase_ff + 2'h1;
		end else if (back) begin
			out_pos_ff <= out_pos_ff - step_units;
			phase_ff <= phase_ff - 2'h1;
		end
	end
	// gray of phase gives a then b changes: b lags a when counting up
	always_ff @(posedge clk) begin
		if (rst) begin
			quad_a <= 1'b0;
			quad_b <= 1'b0;
		end else begin
			quad_a <= phase_ff[1] ^ phase_ff[0];
			quad_b <= phase_ff[1];
		end
	end
	// the stepper moves the phase one way per cycle and the pins follow in gray order
	chk_one_edge_step: assert property (@(posedge clk) disable iff (rst)
		$past(!rst) |-> !($changed(quad_a) && $changed(quad_b)))
		else $error("both quadrature outputs moved at once");
	chk_quad_fwd: assert property (@(posedge clk) disable iff (rst)
		fwd |=> phase_ff == $past(phase_ff) + 2'h1)
		else $error("phase did not advance on forward step");
	chk_quad_back: assert property (@(posedge clk) disable iff (rst)
		back |=> phase_ff == $past(phase_ff) - 2'h1)
		else $error("phase did not fall back on reverse step");
	// a leaves an equal pair only when counting up, so b lags a then
	chk_b_lags_a: assert property (@(posedge clk) disable iff (rst)
		$past(!rst) && $past(!rst, 2) && $changed(quad_a) |->
		$past(quad_a == quad_b) == $past(fwd, 2))
		else $error("quadrature order does not match direction");
	always_ff @(posedge clk) begin
		if (rst) begin
			reference_index_pulse <= 1'b0;
		end else begin
			reference_index_pulse <= ref_mark_seen;
		end
	end
	// link clock synchroniser and edge detection
	logic sclk_s1_ff;
	logic sclk_s2_ff;
	logic sclk_d_ff;
	always_ff @(posedge clk) begin
		if (rst) begin
			sclk_s1_ff <= 1'b1;
			sclk_s2_ff <= 1'b1;
			sclk_d_ff <= 1'b1;
		end else begin
			sclk_s1_ff <= ser_clk;
			sclk_s2_ff <= sclk_s1_ff;
			sclk_d_ff <= sclk_s2_ff;
		end
	end
	logic sclk_fall;
	logic sclk_rise;
	assign sclk_fall = sclk_d_ff && !sclk_s2_ff;
	assign sclk_rise = !sclk_d_ff && sclk_s2_ff;
	// frame builder: msb-aligned word feeds the buffer
	logic [LEI_POS_W-1:0] scaled;
	logic [27:0] gray28;
	logic [LEI_FRAME_W-1:0] frame_word;
	logic [5:0] frame_len;
	always_comb begin
		scaled = '0;
		gray28 = position_units[27:0] ^ (position_units[27:0] >> 1);
		frame_word = '0;
		frame_len = 6'h00;
		unique case (ser_sel)
			LEI_SER_22: begin
				scaled = position_units / LEI_POS_W'(LEI_DIV_10UM);
				frame_word = {scaled[21:0], ^scaled[21:0], pos_error, pos_warning, 7'h00};
				frame_len = 6'(LEI_BITS_22 + 3);
			end
			LEI_SER_25: begin
				scaled = position_units / LEI_POS_W'(LEI_DIV_1UM);
				frame_word = {scaled[24:0], ^scaled[24:0], pos_error, pos_warning, 4'h0};
				frame_len = 6'(LEI_BITS_25 + 3);
			end
			LEI_SER_27: begin
				scaled = position_units >> 1;
				frame_word = {scaled[26:0], pos_error, 4'h0};
				frame_len = 6'(LEI_BITS_27 + 1);
			end
			LEI_SER_G28: begin
				scaled = position_units / LEI_POS_W'(LEI_DIV_0125UM);
				frame_word = {gray28, 4'h0};
				frame_len = 6'(LEI_BITS_28);
			end
		endcase
	end
	lei_buf_if bif ();
	logic buf_valid;
	logic [31:0] buf_data;
	logic buf_take;
	lei_skid_buf u_buf (
		.clk(clk),
		.rst(rst),
		.in_side(bif.dst),
		.out_valid(buf_valid),
		.out_ready(buf_take),
		.out_data(buf_data)
	);
	// latch request: first falling link edge of an idle link
	logic idle_ff;
	assign bif.valid = sclk_fall && idle_ff;
	assign bif.data = frame_word;
	logic [LEI_FRAME_W-1:0] shreg_ff;
	logic [5:0] left_ff;
	logic [10:0] mono_ff;
	assign buf_take = buf_valid && (left_ff == 6'h00);
	always_ff @(posedge clk) begin
		if (rst) begin
			shreg_ff <= '0;
			left_ff <= 6'h00;
			ser_data <= 1'b1;
			frame_busy <= 1'b0;
		end else if (buf_take) begin
			shreg_ff <= buf_data << 1;
			left_ff <= frame_len - 6'h01;
			ser_data <= buf_data[LEI_FRAME_W-1];
			frame_busy <= 1'b1;
		end else if (sclk_rise && left_ff != 6'h00) begin
			shreg_ff <= shreg_ff << 1;
			left_ff <= left_ff - 6'h01;
			ser_data <= shreg_ff[LEI_FRAME_W-1];
		end else if (sclk_rise && frame_busy) begin
			ser_data <= 1'b0;
		end else if (mono_ff == 11'h001) begin
			ser_data <= 1'b1;
			frame_busy <= 1'b0;
		end
	end
	// link idle timeout after the last clock edge
	always_ff @(posedge clk) begin
		if (rst) begin
			mono_ff <= 11'h000;
			idle_ff <= 1'b1;
		end else if (sclk_fall || sclk_rise) begin
			mono_ff <= 11'(LEI_MONO_CYC - 1);
			if (sclk_fall) begin
				idle_ff <= 1'b0;
			end
		end else if (mono_ff != 11'h000) begin
			mono_ff <= mono_ff - 11'h001;
			if (mono_ff == 11'h001) begin
				idle_ff <= 1'b1;
			end
		end
	end
	// one latch per frame; the stepper never waits on the link
	chk_latch_once: assert property (@(posedge clk) disable iff (rst)
		bif.valid |=> !idle_ff)
		else $error("link not marked busy after latch");
	chk_quad_free: assert property (@(posedge clk) disable iff (rst)
		frame_busy && fwd |=> phase_ff != $past(phase_ff))
		else $error("quadrature stalled during serial frame");
	chk_frame_start: assert property (@(posedge clk) disable iff (rst)
		buf_take |=> frame_busy && ser_data == $past(buf_data[LEI_FRAME_W-1]))
		else $error("frame did not start with msb");
	// shifts left after the msb: field plus flags, less the bit already out
	chk_narrow_len: assert property (@(posedge clk) disable iff (rst)
		buf_take && ser_sel == LEI_SER_22 |=> left_ff == 6'(LEI_BITS_22 + 2))
		else $error("short frame has the wrong length");
	chk_gray_len: assert property (@(posedge clk) disable iff (rst)
		buf_take && ser_sel == LEI_SER_G28 |=> left_ff == 6'(LEI_BITS_28 - 1))
		else $error("gray frame has the wrong length");
	// the line rests high whenever no frame is open
	chk_idle_high: assert property (@(posedge clk) disable iff (rst)
		!frame_busy |-> ser_data)
		else $error("serial line low outside a frame");
	chk_busy_timeout: assert property (@(posedge clk) disable iff (rst)
		$past(!rst) && $fell(frame_busy) |-> $past(mono_ff) == 11'h001)
		else $error("frame closed before the link went quiet");
	// parameter channel: synchronised echo of param_rx; 8-bit store written and read in parallel
	logic [7:0] store_ff [16];
	logic pr_s1_ff;
	logic pr_s2_ff;
	always_ff @(posedge clk) begin
		if (rst) begin
			pr_s1_ff <= 1'b1;
			pr_s2_ff <= 1'b1;
		end else begin
			pr_s1_ff <= param_rx;
			pr_s2_ff <= pr_s1_ff;
		end
	end
	always_ff @(posedge clk) begin
		if (hybrid_interface_option && store_we && store_addr != 4'h0) begin
			store_ff[store_addr] <= store_wdata;
		end
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			store_rdata <= 8'h00;
			param_tx <= 1'b1;
			param_tx_oe <= 1'b0;
		end else begin
			store_rdata <= (store_addr == 4'h0) ? LEI_ID_BYTE : store_ff[store_addr];
			param_tx <= pr_s2_ff;
			param_tx_oe <= hybrid_interface_option && !pr_s2_ff;
		end
	end
	chk_id_read: assert property (@(posedge clk) disable iff (rst)
		store_addr == 4'h0 |=> store_rdata == LEI_ID_BYTE)
		else $error("identity byte wrong");
	// the channel pin stays released unless the hybrid option is fitted
	chk_tx_quiet: assert property (@(posedge clk) disable iff (rst)
		!hybrid_interface_option |=> !param_tx_oe)
		else $error("parameter pin driven without the hybrid option");
endmodule
`default_nettype wire

/* File: rtl/lei_pkg.sv */
// package: constants and types for the encoder output block
`default_nettype none
package lei_pkg;
	typedef enum logic [1:0] {
		LEI_RES_FINE,
		LEI_RES_MEDIUM,
		LEI_RES_COARSE
	} lei_res_t;
	typedef enum logic [1:0] {
		LEI_SER_22,
		LEI_SER_25,
		LEI_SER_27,
		LEI_SER_G28
	} lei_ser_t;
	localparam int LEI_POS_W = 32;
	localparam int LEI_FRAME_W = 32;
	localparam int LEI_BITS_22 = 22;
	localparam int LEI_BITS_25 = 25;
	localparam int LEI_BITS_27 = 27;
	localparam int LEI_BITS_28 = 28;
	// position input is in units of 0.125 um; the frame builder scales it per config by divisors, or by a literal right shift of one for 27 bit, not these shifts
	localparam int LEI_SHIFT_22 = 0;
	localparam int LEI_SHIFT_25 = 3;
	localparam int LEI_SHIFT_27 = 1;
	localparam int LEI_SHIFT_28 = 0;
	localparam int LEI_DIV_10UM = 80;
	localparam int LEI_DIV_1UM = 8;
	localparam int LEI_DIV_0125UM = 1;
	localparam int LEI_STEP_FINE_UM = 1;
	localparam int LEI_STEP_MEDIUM_UM = 5;
	localparam int LEI_STEP_COARSE_UM = 10;
	localparam int LEI_UNITS_PER_UM = 8;
	localparam int LEI_CLK_MHZ = 125;
	localparam int LEI_SER_MAX_MHZ = 2;
	// least half period of the link clock in our cycles
	localparam int LEI_SER_HALF_CYC = (LEI_CLK_MHZ + 2 * LEI_SER_MAX_MHZ - 1) / (2 * LEI_SER_MAX_MHZ);
	localparam int LEI_MONO_CYC = 2048;
	localparam logic [1:0] LEI_QUAD_RST = 2'h0;
	localparam int LEI_BUF_DEPTH = 2;
	// identity byte read at store address zero: value is arbitrary
	localparam logic [7:0] LEI_ID_BYTE = 8'h5A;
endpackage
`default_nettype wire

/* File: rtl/lei_skid_buf.sv */
// two-entry valid/ready buffer
`default_nettype none
module lei_skid_buf
	import lei_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	lei_buf_if.dst in_side,
	output logic out_valid,
	input wire logic out_ready,
	output logic [31:0] out_data
);
	logic [31:0] mem_ff [LEI_BUF_DEPTH];
	logic wr_ptr_ff;
	logic rd_ptr_ff;
	logic [1:0] cnt_ff;
	logic push;
	logic pop;
	assign in_side.ready = (cnt_ff != 2'h2);
	assign out_valid = (cnt_ff != 2'h0);
	assign out_data = mem_ff[rd_ptr_ff];
	assign push = in_side.valid && in_side.ready;
	assign pop = out_valid && out_ready;
	always_ff @(posedge clk) begin
		if (push) begin
			mem_ff[wr_ptr_ff] <= in_side.data;
		end
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			wr_ptr_ff <= 1'b0;
			rd_ptr_ff <= 1'b0;
			cnt_ff <= 2'h0;
		end else begin
			if (push) begin
				wr_ptr_ff <= ~wr_ptr_ff;
			end
			if (pop) begin
				rd_ptr_ff <= ~rd_ptr_ff;
			end
			cnt_ff <= cnt_ff + {1'b0, push} - {1'b0, pop};
		end
	end
	chk_no_overflow: assert property (@(posedge clk) disable iff (rst)
		cnt_ff != 2'h3)
		else $error("buffer count beyond its depth");
	chk_first_word: assert property (@(posedge clk) disable iff (rst)
		push && cnt_ff == 2'h0 |=> out_valid && out_data == $past(in_side.data))
		else $error("buffer lost the word pushed into it");
endmodule
`default_nettype wire
